/* hw/pcei_ctrl.sv */
// pin change and external line-0 interrupt controller
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - line-0 trigger under sense mode sets flag
// - line-0 vector needs flag or held low level, global, enable
// - flags clear on entry or write one
// - low-level sense keeps line-0 flag cleared
// - group enable register uses bits 2..0
// - enabled pin change requests group interrupt
// - each group has its own vector
// - group pin change sets group flag
// - group vector needs flag, enable, global
// - group flag cleared when routine runs
// - mask bit acts only with group enable
// - cleared mask bit ignores the pin
// - group1 mask has bits 6..0 only
// - flag register at data and io address
// - all registers reset to zero
// - sense field selects level or edge
// - pin change seen without clock edges; here pins are sampled on sys_clk edges only
// - pins driven as outputs still trigger
`timescale 1ns/1ns
`include "pcei_regs.svh"

module pcei_ctrl
    import pcei_pkg::*;
#(
    parameter int PCEI_GROUP0_W = 8,  // pins 7..0
    parameter int PCEI_GROUP1_W = 7,  // pins 14..8
    parameter int PCEI_GROUP2_W = 8   // pins 23..16
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset,
    // cpu register access
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_io_space,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // cpu interrupt handshake
    input  wire logic                     cpu_global_ie,
    input  wire logic                     irq_ack,
    input  wire logic [2:0]               irq_ack_vec,
    output logic                          irq_req,
    output logic      [2:0]               irq_vec,
    // pins
    input  wire logic                     ext_line0,
    input  wire logic [PCEI_GROUP0_W-1:0] pin_change_input0,
    input  wire logic [PCEI_GROUP1_W-1:0] pin_change_input1,
    input  wire logic [PCEI_GROUP2_W-1:0] pin_change_input2,
    // wake request for the power manager
    output logic                          wake_req
);

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // match either the data-space or io-space form of an address
    // io form sits a fixed offset below the data-space form
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic       io,
                                      input logic [7:0] data_addr);
        addr_hit = io ? (a == data_addr - `PCEI_IO_OFFSET)
                      : (a == data_addr);
    endfunction

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    // software-visible state, all zero after reset
    logic [7:0]               pc_group_flag_reg_q;   // group flags
    logic [7:0]               pc_group_enable_reg_q; // group enables
    logic [PCEI_GROUP0_W-1:0] pc_group0_mask_q;      // group0 mask
    logic [PCEI_GROUP1_W-1:0] pc_group1_mask_q;      // group1 mask
    logic [PCEI_GROUP2_W-1:0] pc_group2_mask_q;      // group2 mask
    logic                     ext_line0_pending_q;   // line-0 flag
    logic                     ext_line0_enable_q;    // line-0 enable
    logic [1:0]               line0_sense_field_q;   // sense mode
    logic [7:0]               reg_rdata_q;           // read data
    logic                     irq_req_q;             // request out
    logic [2:0]               irq_vec_q;             // vector out
    logic                     wake_req_q;            // wake out

    // input sample pipeline: sync stage, sampled, previous
    // the first stage feeds only the second, never any logic
    logic [PCEI_GROUP0_W-1:0] g0_s1_q, g0_s2_q, g0_prev_q;
    logic [PCEI_GROUP1_W-1:0] g1_s1_q, g1_s2_q, g1_prev_q;
    logic [PCEI_GROUP2_W-1:0] g2_s1_q, g2_s2_q, g2_prev_q;
    logic                     l0_s1_q, l0_s2_q, l0_prev_q;

    //------------------------------------------------------------
    // decode
    //------------------------------------------------------------
    // write strobes; enable, masks and sense answer in data space only
    // flag and line-0 registers also answer at their io addresses
    // a strobe is taken on the edge where it stands
    wire wr_flag   = reg_wr & addr_hit(reg_addr, reg_io_space,
                                       `PCEI_FLAG_DATA_ADDR);
    wire wr_enable = reg_wr & !reg_io_space
                   & (reg_addr == `PCEI_ENABLE_ADDR);
    wire wr_mask0  = reg_wr & !reg_io_space
                   & (reg_addr == `PCEI_MASK0_ADDR);
    wire wr_mask1  = reg_wr & !reg_io_space
                   & (reg_addr == `PCEI_MASK1_ADDR);
    wire wr_mask2  = reg_wr & !reg_io_space
                   & (reg_addr == `PCEI_MASK2_ADDR);
    wire wr_eflag  = reg_wr & addr_hit(reg_addr, reg_io_space,
                                       `PCEI_EXT_FLAG_ADDR);
    wire wr_een    = reg_wr & addr_hit(reg_addr, reg_io_space,
                                       `PCEI_EXT_EN_ADDR);
    wire wr_sense  = reg_wr & !reg_io_space
                   & (reg_addr == `PCEI_SENSE_ADDR);

    //------------------------------------------------------------
    // pin change detection
    //------------------------------------------------------------
    // mask gated by group enable; output-driven pins count too
    wire [PCEI_GROUP0_W-1:0] g0_live = pc_group0_mask_q
        & {PCEI_GROUP0_W{pc_group_enable_reg_q[0]}};
    wire [PCEI_GROUP1_W-1:0] g1_live = pc_group1_mask_q
        & {PCEI_GROUP1_W{pc_group_enable_reg_q[1]}};
    wire [PCEI_GROUP2_W-1:0] g2_live = pc_group2_mask_q
        & {PCEI_GROUP2_W{pc_group_enable_reg_q[2]}};

    // a toggle is a mismatch of the sampled and previous stages
    // toggle of any unmasked pin per group
    wire g0_hit = |((g0_s2_q ^ g0_prev_q) & g0_live);
    wire g1_hit = |((g1_s2_q ^ g1_prev_q) & g1_live);
    wire g2_hit = |((g2_s2_q ^ g2_prev_q) & g2_live);
    wire [2:0] grp_hit = {g2_hit, g1_hit, g0_hit};

    // any live toggle, for the wake request; only the second sync
    // stage is compared, so a metastable first stage never leaks out
    wire any_toggle = |grp_hit;

    //------------------------------------------------------------
    // line-0 detection
    //------------------------------------------------------------
    // edges compare the sampled stage against the previous sample
    wire l0_rise = l0_s2_q & !l0_prev_q;
    wire l0_fall = !l0_s2_q & l0_prev_q;
    wire l0_low  = (line0_sense_field_q == PCEI_SENSE_LOW);
    // low level never sets the flag; it requests straight from the pin
    logic l0_trig;
    always_comb begin // sense mode select
        case (pcei_sense_t'(line0_sense_field_q))
            PCEI_SENSE_LOW:     l0_trig = 1'b0;
            PCEI_SENSE_CHANGE:  l0_trig = l0_rise | l0_fall;
            PCEI_SENSE_FALLING: l0_trig = l0_fall;
            PCEI_SENSE_RISING:  l0_trig = l0_rise;
            default:            l0_trig = 1'b0;
        endcase
    end
    // low level requests directly while pin held low
    wire l0_level_req = l0_low & !l0_s2_q;

    //------------------------------------------------------------
    // acknowledge decode
    //------------------------------------------------------------
    // routine entry clears the flag of the vector that was entered
    wire ack_l0 = irq_ack & (irq_ack_vec == PCEI_VEC_LINE0);
    wire [2:0] ack_grp = {
        irq_ack & (irq_ack_vec == PCEI_VEC_GROUP2),
        irq_ack & (irq_ack_vec == PCEI_VEC_GROUP1),
        irq_ack & (irq_ack_vec == PCEI_VEC_GROUP0)};

    // flag next values: set wins over clear
    // a new event in the clearing cycle keeps the flag set
    wire [2:0] grp_clr = ack_grp
        | (wr_flag ? reg_wdata[2:0] : 3'b000);
    wire [2:0] grp_flag_d = (pc_group_flag_reg_q[2:0] & ~grp_clr)
                          | grp_hit;
    wire l0_clr = ack_l0 | (wr_eflag & reg_wdata[`PCEI_LINE0_BIT]);
    wire l0_flag_d = l0_low ? 1'b0
                   : ((ext_line0_pending_q & !l0_clr) | l0_trig);

    //------------------------------------------------------------
    // interrupt arbitration: line 0 first, then group 0..2
    //------------------------------------------------------------
    // a lower source waits while a higher one stands
    wire [2:0] grp_go = pc_group_flag_reg_q[2:0]
        & pc_group_enable_reg_q[2:0]
        & {3{cpu_global_ie}};
    wire l0_go = (ext_line0_pending_q | l0_level_req)
        & ext_line0_enable_q & cpu_global_ie;
    wire [2:0] vec_d = l0_go     ? PCEI_VEC_LINE0
                     : grp_go[0] ? PCEI_VEC_GROUP0
                     : grp_go[1] ? PCEI_VEC_GROUP1
                     : grp_go[2] ? PCEI_VEC_GROUP2
                     :             PCEI_VEC_NONE;
    wire req_d = l0_go | (|grp_go);

    //------------------------------------------------------------
    // read mux
    //------------------------------------------------------------
    // registered read data, zero when idle or unmapped
    // io space reaches only the flag and line-0 registers
    wire [7:0] mask1_rd = {1'b0, pc_group1_mask_q};
    wire [7:0] rdata_d =
        !reg_rd ? 8'h00
        : addr_hit(reg_addr, reg_io_space, `PCEI_FLAG_DATA_ADDR)
            ? pc_group_flag_reg_q
        : addr_hit(reg_addr, reg_io_space, `PCEI_EXT_FLAG_ADDR)
            ? {7'h00, ext_line0_pending_q}
        : addr_hit(reg_addr, reg_io_space, `PCEI_EXT_EN_ADDR)
            ? {7'h00, ext_line0_enable_q}
        : reg_io_space ? 8'h00
        : (reg_addr == `PCEI_ENABLE_ADDR) ? pc_group_enable_reg_q
        : (reg_addr == `PCEI_MASK0_ADDR)  ? pc_group0_mask_q
        : (reg_addr == `PCEI_MASK1_ADDR)  ? mask1_rd
        : (reg_addr == `PCEI_MASK2_ADDR)  ? pc_group2_mask_q
        : (reg_addr == `PCEI_SENSE_ADDR)  ? {6'h00, line0_sense_field_q}
        : 8'h00;

    //------------------------------------------------------------
    // input sampling
    //------------------------------------------------------------
    // two-stage sync, then previous-value register for compare
    // pin samples are not reset; live masks stay zero until written
    always_ff @(posedge sys_clk) begin
        g0_s1_q <= pin_change_input0;
        g1_s1_q <= pin_change_input1;
        g2_s1_q <= pin_change_input2;
        l0_s1_q <= ext_line0;
        g0_s2_q <= g0_s1_q;
        g1_s2_q <= g1_s1_q;
        g2_s2_q <= g2_s1_q;
        l0_s2_q <= l0_s1_q;
        g0_prev_q <= g0_s2_q;
        g1_prev_q <= g1_s2_q;
        g2_prev_q <= g2_s2_q;
        l0_prev_q <= l0_s2_q;
    end

    //------------------------------------------------------------
    // control registers
    //------------------------------------------------------------
    // software-written control registers, synchronous reset
    // unused enable bits and group1 mask bit 7 never store
    // a write lands on the edge where its strobe stands
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pc_group_enable_reg_q <= `PCEI_REG_RESET;
            pc_group0_mask_q      <= '0;
            pc_group1_mask_q      <= '0;
            pc_group2_mask_q      <= '0;
            ext_line0_enable_q    <= 1'b0;
            line0_sense_field_q   <= 2'b00;
        end else begin
            if (wr_enable) begin
                pc_group_enable_reg_q <= reg_wdata & `PCEI_GROUP_MASK;
            end
            if (wr_mask0) begin
                pc_group0_mask_q <= reg_wdata[PCEI_GROUP0_W-1:0];
            end
            if (wr_mask1) begin
                pc_group1_mask_q <= reg_wdata[PCEI_GROUP1_W-1:0];
            end
            if (wr_mask2) begin
                pc_group2_mask_q <= reg_wdata[PCEI_GROUP2_W-1:0];
            end
            if (wr_een) begin
                ext_line0_enable_q <= reg_wdata[`PCEI_LINE0_BIT];
            end
            if (wr_sense) begin
                line0_sense_field_q <= reg_wdata[1:0];
            end
        end
    end

    //------------------------------------------------------------
    // flags and outputs
    //------------------------------------------------------------
    // flags, read data and cpu-facing outputs, all registered
    // request drops the cycle after routine entry
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pc_group_flag_reg_q <= `PCEI_REG_RESET;
            ext_line0_pending_q <= 1'b0;
            reg_rdata_q         <= 8'h00;
            irq_req_q           <= 1'b0;
            irq_vec_q           <= 3'h0;
            wake_req_q          <= 1'b0;
        end else begin
            pc_group_flag_reg_q <= {5'h00, grp_flag_d};
            ext_line0_pending_q <= l0_flag_d;
            reg_rdata_q         <= rdata_d;
            irq_req_q           <= req_d & !irq_ack;
            irq_vec_q           <= irq_ack ? 3'h0 : vec_d;
            wake_req_q          <= any_toggle | l0_level_req;
        end
    end

    // every port comes straight from its flop
    assign reg_rdata = reg_rdata_q;
    assign irq_req   = irq_req_q;
    assign irq_vec   = irq_vec_q;
    assign wake_req  = wake_req_q;

endmodule // pcei_ctrl

/* hw/pcei_pkg.sv */
// types shared by the pin change and line-0 interrupt block
package pcei_pkg;

    // line-0 sense modes
    typedef enum logic [1:0] {
        PCEI_SENSE_LOW     = 2'b00,
        PCEI_SENSE_CHANGE  = 2'b01,
        PCEI_SENSE_FALLING = 2'b10,
        PCEI_SENSE_RISING  = 2'b11
    } pcei_sense_t;

    // vector identifiers raised toward the cpu
    typedef enum logic [2:0] {
        PCEI_VEC_NONE   = 3'b000,
        PCEI_VEC_LINE0  = 3'b001,
        PCEI_VEC_GROUP0 = 3'b010,
        PCEI_VEC_GROUP1 = 3'b011,
        PCEI_VEC_GROUP2 = 3'b100
    } pcei_vec_t;

endpackage

/* hw/pcei_regs.svh */
// register offsets, field positions and reset values of the pin change block
`ifndef PCEI_REGS_SVH
`define PCEI_REGS_SVH

`define PCEI_IO_OFFSET      8'h20
`define PCEI_FLAG_DATA_ADDR 8'h3b
`define PCEI_FLAG_IO_ADDR   8'h1b
`define PCEI_ENABLE_ADDR    8'h68
`define PCEI_MASK0_ADDR     8'h6b
`define PCEI_MASK1_ADDR     8'h6c
`define PCEI_MASK2_ADDR     8'h6d
`define PCEI_EXT_FLAG_ADDR  8'h3c
`define PCEI_EXT_EN_ADDR    8'h3d
`define PCEI_SENSE_ADDR     8'h69
`define PCEI_REG_RESET      8'h00
`define PCEI_GROUP_MASK     8'h07
`define PCEI_MASK1_BITS     8'h7f
`define PCEI_LINE0_BIT      0
`define PCEI_SENSE_MASK     8'h03

`endif

/* verif/pcei_checker.sv */
// assertion checker for the pin change and line-0 interrupt controller
`timescale 1ns/1ns
module pcei_checker (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // register bus
    input wire logic [7:0] reg_addr,
    input wire logic       reg_io_space,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // cpu interrupt handshake
    input wire logic       cpu_global_ie,
    input wire logic       irq_ack,
    input wire logic [2:0] irq_ack_vec,
    input wire logic       irq_req,
    input wire logic [2:0] irq_vec
);
    //--------------------------------------------------------
    // properties
    //--------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire logic rd_data_sp = reg_rd && !reg_io_space;  // data-space read

    property p_rst_quiet;
        disable iff (1'b0) reset |=> !irq_req && reg_rdata == 8'h00;
    endproperty
    property p_no_ie;
        !cpu_global_ie |=> !irq_req;
    endproperty
    property p_vec_ok;
        irq_req |-> irq_vec inside {3'h1, 3'h2, 3'h3, 3'h4};
    endproperty
    property p_ack_drop;
        irq_ack && irq_req && irq_ack_vec == irq_vec
            |-> ##2 (!irq_req || irq_vec != $past(irq_vec, 2));
    endproperty
    property p_req_holds;
        irq_req && cpu_global_ie && !irq_ack && !$past(irq_ack)
            && !reg_wr && !$past(reg_wr) |=> irq_req;
    endproperty
    property p_rd_enable;
        rd_data_sp && reg_addr == 8'h68 |=> reg_rdata[7:3] == 5'h00;
    endproperty
    property p_rd_mask1;
        rd_data_sp && reg_addr == 8'h6c |=> !reg_rdata[7];
    endproperty
    property p_rd_flags;
        rd_data_sp && reg_addr == 8'h3b |=> reg_rdata[7:3] == 5'h00;
    endproperty
    property p_io_gap;
        reg_rd && reg_io_space && reg_addr == 8'h48 |=> reg_rdata == 8'h00;
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_no_ie: assert property (p_no_ie)
        else $error("request without global enable");
    a_vec_ok: assert property (p_vec_ok)
        else $error("request with bad vector");
    a_ack_drop: assert property (p_ack_drop)
        else $error("request stands after routine entry");
    a_req_holds: assert property (p_req_holds)
        else $error("request dropped with no cause");
    a_rd_enable: assert property (p_rd_enable)
        else $error("unused enable bits read nonzero");
    a_rd_mask1: assert property (p_rd_mask1)
        else $error("group1 mask bit7 reads nonzero");
    a_rd_flags: assert property (p_rd_flags)
        else $error("unused flag bits read nonzero");
    a_io_gap: assert property (p_io_gap)
        else $error("io read of unmapped place nonzero");

    c_group2: cover property (irq_req && irq_vec == 3'h4);
    c_line0: cover property (irq_req && irq_vec == 3'h1);
    c_ack: cover property (irq_ack && irq_req);
endmodule // pcei_checker

bind pcei_ctrl pcei_checker i_pcei_checker (.sys_clk, .reset, .reg_addr,
    .reg_io_space, .reg_wr, .reg_rd, .reg_rdata, .cpu_global_ie, .irq_ack,
    .irq_ack_vec, .irq_req, .irq_vec);

/* verif/pcei_cpu_model.sv */
// cpu side model that enters interrupt routines after a set delay
`timescale 1ns/1ns
module pcei_cpu_model (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // bench controls
    input wire logic       ack_en,
    input wire logic [3:0] ack_dly,
    // interrupt handshake
    input wire logic       irq_req,
    input wire logic [2:0] irq_vec,
    output logic           irq_ack,
    output logic     [2:0] irq_ack_vec
);
    logic [3:0] wait_q;  // cycles spent waiting on a request
    // one-cycle entry pulse, held off after each entry
    always @(negedge sys_clk) begin
        if (reset || irq_ack) begin
            irq_ack <= 1'b0;
            irq_ack_vec <= 3'h0;
            wait_q <= 4'h0;
        end else if (irq_req && ack_en) begin
            if (wait_q >= ack_dly) begin
                irq_ack <= 1'b1;
                irq_ack_vec <= irq_vec;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule // pcei_cpu_model

/* verif/tb_top.sv */
// self-checking bench for the pin change and line-0 interrupt controller
`timescale 1ns/1ns
module tb_top
    import pcei_pkg::*;
;
    //--------------------------------------------------------
    // stimulus and instances
    //--------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_io_space = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        cpu_global_ie = 1'b0;
    logic        ack_en = 1'b0;
    logic [3:0]  ack_dly = 4'h6;
    logic [24:0] pins = 25'h1000000;  // bit 24 is the line-0 pin
    logic [7:0]  reg_rdata, v;
    logic [2:0]  irq_vec, irq_ack_vec;
    logic        irq_req, irq_ack, wake_req;
    logic [7:0]  ra [5] = '{8'h3b, 8'h68, 8'h6b, 8'h6c, 8'h6d};
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #10 sys_clk = ~sys_clk;

    pcei_ctrl i_pcei_ctrl (.sys_clk, .reset, .reg_addr, .reg_io_space,
        .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cpu_global_ie, .irq_ack,
        .irq_ack_vec, .irq_req, .irq_vec, .ext_line0(pins[24]),
        .pin_change_input0(pins[7:0]), .pin_change_input1(pins[14:8]),
        .pin_change_input2(pins[23:16]), .wake_req);
    pcei_cpu_model i_pcei_cpu_model (.sys_clk, .reset, .ack_en, .ack_dly,
        .irq_req, .irq_vec, .irq_ack, .irq_ack_vec);

    //--------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one register access, data taken the cycle after the strobe
    task automatic acc(input logic [7:0] a, input logic io, input logic w,
                       input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_io_space = io;
        reg_wr = w;
        reg_rd = !w;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b0, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] e);
        acc(a, io, 1'b0, 8'h00);
        check(v, e);
    endtask
    // drive one pin, then let the flag and request settle
    task automatic pin(input int b, input logic lv);
        @(negedge sys_clk);
        pins[b] = lv;
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    //--------------------------------------------------------
    // scenarios
    //--------------------------------------------------------
    task automatic t_regs();
        foreach (ra[i]) rd(ra[i], 1'b0, 8'h00);
        wr(8'h68, 8'hff);
        rd(8'h68, 1'b0, 8'h07);
        rd(8'h48, 1'b1, 8'h00);
        wr(8'h6c, 8'hff);
        rd(8'h6c, 1'b0, 8'h7f);
        wr(8'h6d, 8'ha5);
        rd(8'h6d, 1'b0, 8'ha5);
        rd(8'h70, 1'b0, 8'h00);
        foreach (ra[i]) wr(ra[i], 8'h00);
    endtask
    task automatic t_mask();
        wr(8'h6b, 8'h01);
        wr(8'h68, 8'h01);
        pin(1, ~pins[1]);
        rd(8'h3b, 1'b0, 8'h00);
        wr(8'h68, 8'h00);
        pin(0, ~pins[0]);
        rd(8'h3b, 1'b0, 8'h00);
        wr(8'h68, 8'h01);
        pin(0, ~pins[0]);
        check({7'h00, irq_req}, 8'h00);
        rd(8'h3b, 1'b0, 8'h01);
        wr(8'h3b, 8'h01);
        rd(8'h3b, 1'b0, 8'h00);
        pin(0, ~pins[0]);
        rd(8'h3b, 1'b0, 8'h01);
        acc(8'h1b, 1'b1, 1'b1, 8'h01);
        rd(8'h3b, 1'b0, 8'h00);
    endtask
    task automatic t_group(input int g);
        wr(8'h6b + 8'(g), 8'h01);
        wr(8'h68, 8'h01 << g);
        cpu_global_ie = 1'b1;
        ack_en = 1'b0;
        pin(8 * g, ~pins[8 * g]);
        check({7'h00, irq_req}, 8'h01);
        check({5'h00, irq_vec}, 8'(2 + g));
        rd(8'h1b, 1'b1, 8'h01 << g);
        ack_en = 1'b1;
        for (int i = 0; i < 20 && irq_req; i++) @(negedge sys_clk);
        check({7'h00, irq_req}, 8'h00);
        rd(8'h3b, 1'b0, 8'h00);
        wr(8'h6b + 8'(g), 8'h00);
        ack_en = 1'b0;
    endtask
    task automatic t_line0();
        cpu_global_ie = 1'b0;
        wr(8'h3d, 8'h01);
        for (int m = 1; m < 4; m++) begin
            wr(8'h69, 8'(m));
            wr(8'h3c, 8'h01);
            pin(24, 1'b0);
            rd(8'h3c, 1'b0, {7'h00, m != 3});
            wr(8'h3c, 8'h01);
            pin(24, 1'b1);
            rd(8'h3c, 1'b0, {7'h00, m != 2});
        end
        wr(8'h69, 8'h01);
        wr(8'h3c, 8'h01);
        cpu_global_ie = 1'b1;
        pin(24, 1'b0);
        check({5'h00, irq_vec}, {5'h00, PCEI_VEC_LINE0});
        ack_dly = 4'h1;
        ack_en = 1'b1;
        repeat (6) @(negedge sys_clk);
        rd(8'h3c, 1'b0, 8'h00);
        cpu_global_ie = 1'b0;
        wr(8'h69, {6'h00, PCEI_SENSE_LOW});
        pin(24, 1'b1);
        check({7'h00, wake_req}, 8'h00);
        pin(24, 1'b0);
        check({7'h00, wake_req}, 8'h01);
        rd(8'h3c, 1'b0, 8'h00);
        wr(8'h3d, 8'h00);
    endtask

    //--------------------------------------------------------
    // main sequence and hang limit
    //--------------------------------------------------------
    initial begin
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_regs();
        t_mask();
        for (int g = 0; g < 3; g++) t_group(g);
        t_line0();
        print_verdict();
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
endmodule // tb_top
